// File: design/irt_timer_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module irt_timer_ctrl (
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic I_REG_WR,
	input wire logic [3:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_NARROW_RUN,
	input wire logic I_NARROW_TOGGLE,
	input wire logic I_WIDE_TERMINAL,
	input wire logic I_WIDE_CAPTURE,
	input wire logic I_PORT_COMBINED,
	input wire logic I_PORT_WIDE,
	input wire logic I_DEMOD_PIN_A,
	input wire logic I_DEMOD_PIN_B,
	output logic [7:0] O_REG_RDATA,
	output logic O_COMBINED_OUTPUT_PIN,
	output logic O_WIDE_TIMER_OUTPUT_PIN,
	output logic O_NARROW_TIMER_OUTPUT,
	output logic O_WIDE_TIMER_OUTPUT,
	output logic O_WIDE_TIMER_RUN,
	output logic O_WIDE_SINGLE_PASS,
	output logic O_WIDE_EDGE_ENABLE,
	output logic O_WIDE_PRESCALE_TICK,
	output logic O_PING_PONG,
	output logic O_DEMOD_MODE,
	output logic O_EDGE_RISE,
	output logic O_EDGE_FALL,
	output logic O_WIDE_CAPTURE_IRQ,
	output logic O_WIDE_TIMEOUT_IRQ
);

	function automatic logic combine(input logic [1:0] fn, input logic a, input logic b);
		logic r;
		r = 1'b0;
		unique case (fn)
			irt_pkg::IRT_FN_AND: r = a & b;
			irt_pkg::IRT_FN_OR: r = a | b;
			irt_pkg::IRT_FN_NOR: r = ~(a | b);
			irt_pkg::IRT_FN_NAND: r = ~(a & b);
		endcase
		return r;
	endfunction

	function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h7;
		unique case (sel)
			irt_pkg::IRT_PRE_DIV1: m = 3'h0;
			irt_pkg::IRT_PRE_DIV2: m = 3'h1;
			irt_pkg::IRT_PRE_DIV4: m = 3'h3;
			default: m = 3'h7;
		endcase
		return m;
	endfunction

	logic [7:0] shared_ctl;
	logic [7:0] wide_ctl;
	logic [7:0] next_shared_ctl;
	logic [7:0] next_wide_ctl;
	logic narrow_out;
	logic wide_out;
	logic narrow_run_d;
	logic wide_run_d;
	logic [2:0] pre_cnt;
	logic filt;
	logic filt_d;
	logic [3:0] filt_cnt;

	// register decode
	wire wr_shared = I_REG_WR && (I_REG_ADDR == irt_pkg::IRT_SHARED_OFS);
	wire wr_wide = I_REG_WR && (I_REG_ADDR == irt_pkg::IRT_WIDE_OFS);
	wire [7:0] rd_mux = (I_REG_ADDR == irt_pkg::IRT_SHARED_OFS) ? shared_ctl :
		(I_REG_ADDR == irt_pkg::IRT_WIDE_OFS) ? wide_ctl : 8'h00;

	// shared control fields, then the wide run and prescale fields
	wire demod = shared_ctl[irt_pkg::IRT_MODE_BIT];
	wire sel = shared_ctl[irt_pkg::IRT_SEL_BIT];
	wire [1:0] fn = shared_ctl[irt_pkg::IRT_FN_HI:irt_pkg::IRT_FN_LO];
	wire [1:0] sub = shared_ctl[irt_pkg::IRT_SUB_HI:irt_pkg::IRT_SUB_LO];
	wire narrow_init = shared_ctl[irt_pkg::IRT_NARROW_INIT_BIT];
	wire wide_init = shared_ctl[irt_pkg::IRT_WIDE_INIT_BIT];
	wire wide_run = wide_ctl[irt_pkg::IRT_RUN_BIT];
	wire [1:0] pre_sel = wide_ctl[irt_pkg::IRT_PRE_HI:irt_pkg::IRT_PRE_LO];

	// demodulation input path
	wire fin = sel ? I_DEMOD_PIN_B : I_DEMOD_PIN_A;
	wire [3:0] filt_width = (!demod) ? 4'h0 :
		(sub == irt_pkg::IRT_FILT_SHORT) ? irt_pkg::IRT_FILT_SHORT_CYCLES :
		(sub == irt_pkg::IRT_FILT_LONG) ? irt_pkg::IRT_FILT_LONG_CYCLES : 4'h0;
	wire filt_take = (filt_width == 4'h0) || (fin != filt && filt_cnt == filt_width - 4'h1);
	wire raw_rise = filt && !filt_d;
	wire raw_fall = !filt && filt_d;
	// reserved code 11 reports nothing
	wire rise_rep = demod && raw_rise && (fn == irt_pkg::IRT_EDGE_RISE || fn == irt_pkg::IRT_EDGE_BOTH);
	wire fall_rep = demod && raw_fall && (fn == irt_pkg::IRT_EDGE_FALL || fn == irt_pkg::IRT_EDGE_BOTH);

	// transmit output path
	wire forced = !demod && sub[1];
	wire narrow_start = I_NARROW_RUN && !narrow_run_d;
	wire wide_start = wide_run && !wide_run_d;
	wire next_narrow_out = demod ? narrow_out :
		!I_NARROW_RUN ? ~narrow_init :
		narrow_start ? narrow_init :
		I_NARROW_TOGGLE ? ~narrow_out : narrow_out;
	wire next_wide_out = forced ? sub[0] :
		demod ? wide_out :
		!wide_run ? ~wide_init :
		wide_start ? wide_init :
		I_WIDE_TERMINAL ? ~wide_out : wide_out;
	wire combined_sel = !demod && sel;
	wire next_combined = combined_sel ? combine(fn, narrow_out, wide_out) : I_PORT_COMBINED;
	wire next_wide_pin = wide_ctl[irt_pkg::IRT_PIN_SEL_BIT] ? wide_out : I_PORT_WIDE;
	wire next_pingpong = !demod && (sub == irt_pkg::IRT_SUB_PINGPONG);
	wire next_single = !demod && wide_ctl[irt_pkg::IRT_SINGLE_BIT];
	wire next_edge_en = demod && !wide_ctl[irt_pkg::IRT_SINGLE_BIT];
	wire [2:0] pmask = prescale_mask(pre_sel);
	wire next_tick = wide_run && ((pre_cnt & pmask) == pmask);

	always_comb begin
		next_shared_ctl = shared_ctl;
		if (wr_shared) begin
			next_shared_ctl[7:2] = I_REG_WDATA[7:2];
			// in demodulation the low bits are write-one-to-clear flags
			if (demod) begin
				next_shared_ctl[1:0] = shared_ctl[1:0] & ~I_REG_WDATA[1:0];
			end else begin
				next_shared_ctl[1:0] = I_REG_WDATA[1:0];
			end
		end
		// a set in the same cycle as a clear wins
		if (rise_rep) begin
			next_shared_ctl[irt_pkg::IRT_NARROW_INIT_BIT] = 1'b1;
		end
		if (fall_rep) begin
			next_shared_ctl[irt_pkg::IRT_WIDE_INIT_BIT] = 1'b1;
		end
	end

	always_comb begin
		next_wide_ctl = wide_ctl;
		if (wr_wide) begin
			next_wide_ctl = I_REG_WDATA;
			next_wide_ctl[irt_pkg::IRT_TIMEOUT_BIT] = wide_ctl[irt_pkg::IRT_TIMEOUT_BIT] &
				~I_REG_WDATA[irt_pkg::IRT_TIMEOUT_BIT];
		end
		if (I_WIDE_TERMINAL) begin
			next_wide_ctl[irt_pkg::IRT_TIMEOUT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			shared_ctl <= irt_pkg::IRT_SHARED_RESET;
			wide_ctl <= irt_pkg::IRT_WIDE_RESET;
		end else begin
			shared_ctl <= next_shared_ctl;
			wide_ctl <= next_wide_ctl;
		end
	end

	// glitch filter: a level is taken only after it has stood for the full width
	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			filt <= 1'b0;
			filt_d <= 1'b0;
			filt_cnt <= 4'h0;
		end else begin
			filt_d <= filt;
			if (filt_take) begin
				filt <= fin;
				filt_cnt <= 4'h0;
			end else if (fin == filt) begin
				filt_cnt <= 4'h0;
			end else begin
				filt_cnt <= filt_cnt + 4'h1;
			end
		end
	end

	// prescaler restarts with every start so the first tick lands predictably
	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pre_cnt <= 3'h0;
		end else if (!wide_run) begin
			pre_cnt <= 3'h0;
		end else begin
			pre_cnt <= pre_cnt + 3'h1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			narrow_out <= 1'b1;
			wide_out <= 1'b1;
			narrow_run_d <= 1'b0;
			wide_run_d <= 1'b0;
		end else begin
			narrow_out <= next_narrow_out;
			wide_out <= next_wide_out;
			narrow_run_d <= I_NARROW_RUN;
			wide_run_d <= wide_run;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_REG_RDATA <= 8'h00;
			O_COMBINED_OUTPUT_PIN <= 1'b0;
			O_WIDE_TIMER_OUTPUT_PIN <= 1'b0;
			O_PING_PONG <= 1'b0;
			O_DEMOD_MODE <= 1'b0;
			O_EDGE_RISE <= 1'b0;
			O_EDGE_FALL <= 1'b0;
			O_WIDE_PRESCALE_TICK <= 1'b0;
			O_WIDE_CAPTURE_IRQ <= 1'b0;
			O_WIDE_TIMEOUT_IRQ <= 1'b0;
			O_WIDE_SINGLE_PASS <= 1'b0;
			O_WIDE_EDGE_ENABLE <= 1'b0;
		end else begin
			O_REG_RDATA <= rd_mux;
			O_COMBINED_OUTPUT_PIN <= next_combined;
			O_WIDE_TIMER_OUTPUT_PIN <= next_wide_pin;
			O_PING_PONG <= next_pingpong;
			O_DEMOD_MODE <= demod;
			O_EDGE_RISE <= rise_rep;
			O_EDGE_FALL <= fall_rep;
			O_WIDE_PRESCALE_TICK <= next_tick;
			O_WIDE_CAPTURE_IRQ <= I_WIDE_CAPTURE && wide_ctl[irt_pkg::IRT_CAP_MASK_BIT];
			O_WIDE_TIMEOUT_IRQ <= I_WIDE_TERMINAL && wide_ctl[irt_pkg::IRT_TO_MASK_BIT];
			O_WIDE_SINGLE_PASS <= next_single;
			O_WIDE_EDGE_ENABLE <= next_edge_en;
		end
	end

	// plain copies of control state toward the counting engines
	assign O_NARROW_TIMER_OUTPUT = narrow_out;
	assign O_WIDE_TIMER_OUTPUT = wide_out;
	assign O_WIDE_TIMER_RUN = wide_run;

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESET_N);

	ping_pong_a: assert property ((!demod && sub == 2'h1) ##1 (!demod && sub == 2'h0) |=> !O_PING_PONG)
		else $error("ping-pong not ended by normal setting");

	force_low_a: assert property ((wr_shared && !demod && I_REG_WDATA[7] == 1'b0 && I_REG_WDATA[3:2] == 2'h2)
		##1 !wr_shared |=> !wide_out)
		else $error("wide output not forced low");

	combine_and_a: assert property ((!demod && sel && fn == 2'h0) |=>
		O_COMBINED_OUTPUT_PIN == ($past(narrow_out) & $past(wide_out)))
		else $error("combined output is not the AND");

	port_pass_a: assert property ((!demod && !sel) |=> O_COMBINED_OUTPUT_PIN == $past(I_PORT_COMBINED))
		else $error("port value not passed to combined pin");

	narrow_idle_a: assert property ((!demod && !I_NARROW_RUN) |=> narrow_out == !$past(narrow_init))
		else $error("idle narrow output not complement of initial");

	narrow_start_a: assert property ((!demod && narrow_start) |=> narrow_out == $past(narrow_init))
		else $error("narrow output not initial level at start");

	wide_start_a: assert property ((!demod && !sub[1] && wide_start) |=> wide_out == $past(wide_init))
		else $error("wide output not initial level at start");

	rise_flag_a: assert property (rise_rep |=> shared_ctl[1] && O_EDGE_RISE)
		else $error("rising edge did not set its flag");

	fall_keep_a: assert property ((demod && shared_ctl[0] && !I_REG_WDATA[0]) |=> shared_ctl[0])
		else $error("falling flag lost without a one written");

	filter_short_a: assert property (($rose(filt) && $past(filt_width) == 4'h4) |->
		$past(fin, 1) && $past(fin, 2) && $past(fin, 3) && $past(fin, 4))
		else $error("filter passed a pulse under four clocks");

	timeout_set_a: assert property (I_WIDE_TERMINAL |=> wide_ctl[5] ##1 (wide_ctl[5] || $past(wr_wide)))
		else $error("time-out flag not set or dropped");

	timeout_irq_a: assert property (O_WIDE_TIMEOUT_IRQ |-> $past(wide_ctl[1]) && $past(I_WIDE_TERMINAL))
		else $error("time-out interrupt without mask or terminal count");

	run_write_a: assert property ((wr_wide && I_REG_WDATA[7]) |=> O_WIDE_TIMER_RUN)
		else $error("wide timer did not start on write");

	input_select_a: assert property ((demod && sub == 2'h0) |=>
		filt == ($past(sel) ? $past(I_DEMOD_PIN_B) : $past(I_DEMOD_PIN_A)))
		else $error("demodulator input not taken from selected pin");

	fall_flag_a: assert property (fall_rep |=> shared_ctl[0] && O_EDGE_FALL)
		else $error("falling edge did not set its flag");

	edge_reserved_a: assert property ((demod && fn == 2'h3) |=> !O_EDGE_RISE && !O_EDGE_FALL)
		else $error("reserved edge code reported an edge");

	wide_idle_a: assert property ((!demod && !sub[1] && !wide_run) |=> wide_out == !$past(wide_init))
		else $error("idle wide output not complement of initial");

	force_high_a: assert property ((!demod && sub == 2'h3) |=> wide_out)
		else $error("wide output not forced high");

	capture_irq_a: assert property (O_WIDE_CAPTURE_IRQ |-> $past(wide_ctl[2]) && $past(I_WIDE_CAPTURE))
		else $error("capture interrupt without mask or capture");

	wide_pin_a: assert property (wide_ctl[0] |=> O_WIDE_TIMER_OUTPUT_PIN == $past(wide_out))
		else $error("wide output not routed to its pin");

	wide_port_a: assert property (!wide_ctl[0] |=> O_WIDE_TIMER_OUTPUT_PIN == $past(I_PORT_WIDE))
		else $error("port value not passed to wide pin");

	single_pass_a: assert property (!demod |=> O_WIDE_SINGLE_PASS == $past(wide_ctl[6]))
		else $error("single pass select does not follow its bit");

	edge_enable_a: assert property (demod |=> O_WIDE_EDGE_ENABLE == !$past(wide_ctl[6]))
		else $error("edge enable does not follow its bit");

	tick_full_a: assert property ((wide_run && pre_sel == 2'h0) |=> O_WIDE_PRESCALE_TICK)
		else $error("undivided prescaler missed a tick");

	tick_idle_a: assert property (!wide_run |=> !O_WIDE_PRESCALE_TICK)
		else $error("prescaler ticked while stopped");

	demod_hold_a: assert property (demod |=> narrow_out == $past(narrow_out) && wide_out == $past(wide_out))
		else $error("timer outputs moved in demodulation mode");

endmodule

`default_nettype wire

// File: design/irt_pkg.sv
package irt_pkg;

	// register offsets inside the counter/timer expanded register group
	localparam logic [3:0] IRT_SHARED_OFS = 4'h1;
	localparam logic [3:0] IRT_WIDE_OFS = 4'h2;

	// timer_shared_control field positions
	localparam int IRT_MODE_BIT = 7;
	localparam int IRT_SEL_BIT = 6;
	localparam int IRT_FN_HI = 5;
	localparam int IRT_FN_LO = 4;
	localparam int IRT_SUB_HI = 3;
	localparam int IRT_SUB_LO = 2;
	localparam int IRT_NARROW_INIT_BIT = 1;
	localparam int IRT_WIDE_INIT_BIT = 0;

	// wide_timer_control field positions
	localparam int IRT_RUN_BIT = 7;
	localparam int IRT_SINGLE_BIT = 6;
	localparam int IRT_TIMEOUT_BIT = 5;
	localparam int IRT_PRE_HI = 4;
	localparam int IRT_PRE_LO = 3;
	localparam int IRT_CAP_MASK_BIT = 2;
	localparam int IRT_TO_MASK_BIT = 1;
	localparam int IRT_PIN_SEL_BIT = 0;

	localparam logic [7:0] IRT_SHARED_RESET = 8'h00;
	localparam logic [7:0] IRT_WIDE_RESET = 8'h00;

	// two-bit field codes
	localparam logic [1:0] IRT_FN_AND = 2'h0;
	localparam logic [1:0] IRT_FN_OR = 2'h1;
	localparam logic [1:0] IRT_FN_NOR = 2'h2;
	localparam logic [1:0] IRT_FN_NAND = 2'h3;
	localparam logic [1:0] IRT_EDGE_FALL = 2'h0;
	localparam logic [1:0] IRT_EDGE_RISE = 2'h1;
	localparam logic [1:0] IRT_EDGE_BOTH = 2'h2;
	localparam logic [1:0] IRT_SUB_NORMAL = 2'h1 - 2'h1;
	localparam logic [1:0] IRT_SUB_PINGPONG = 2'h1;
	localparam logic [1:0] IRT_FILT_SHORT = 2'h1;
	localparam logic [1:0] IRT_FILT_LONG = 2'h2;
	localparam logic [1:0] IRT_PRE_DIV1 = 2'h0;
	localparam logic [1:0] IRT_PRE_DIV2 = 2'h1;
	localparam logic [1:0] IRT_PRE_DIV4 = 2'h2;

	// glitch filter widths in system clock cycles
	localparam logic [3:0] IRT_FILT_SHORT_CYCLES = 4'h4;
	localparam logic [3:0] IRT_FILT_LONG_CYCLES = 4'h8;

endpackage

// File: verif/test_ir_timer_shared_and_wide_control.sv
`timescale 1ns/1ns
`default_nettype none

module test_ir_timer_shared_and_wide_control;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic n_run = 1'b0, n_tog = 1'b0, term = 1'b0, cap = 1'b0;
	logic port_comb = 1'b0, port_wide = 1'b0;
	logic [1:0] pins = 2'h0;
	wire logic [7:0] rdata;
	wire logic comb_pin, wide_pin, n_out, w_out, w_run, single, edge_en, tick;
	wire logic pp, demod, e_rise, e_fall, cap_irq, to_irq;
	int num_errors = 0;
	int samples_checked = 0;
	int ticks;
	logic [31:0] seed = 32'h54c3ae7f;
	logic [7:0] d;
	int n_rise, n_fall;
	logic [3:0] ua;

	irt_timer_ctrl i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_REG_WR(wr), .I_REG_ADDR(addr),
		.I_REG_WDATA(wdata), .I_NARROW_RUN(n_run), .I_NARROW_TOGGLE(n_tog), .I_WIDE_TERMINAL(term),
		.I_WIDE_CAPTURE(cap), .I_PORT_COMBINED(port_comb), .I_PORT_WIDE(port_wide),
		.I_DEMOD_PIN_A(pins[0]), .I_DEMOD_PIN_B(pins[1]), .O_REG_RDATA(rdata),
		.O_COMBINED_OUTPUT_PIN(comb_pin), .O_WIDE_TIMER_OUTPUT_PIN(wide_pin),
		.O_NARROW_TIMER_OUTPUT(n_out), .O_WIDE_TIMER_OUTPUT(w_out), .O_WIDE_TIMER_RUN(w_run),
		.O_WIDE_SINGLE_PASS(single), .O_WIDE_EDGE_ENABLE(edge_en), .O_WIDE_PRESCALE_TICK(tick),
		.O_PING_PONG(pp), .O_DEMOD_MODE(demod), .O_EDGE_RISE(e_rise), .O_EDGE_FALL(e_fall),
		.O_WIDE_CAPTURE_IRQ(cap_irq), .O_WIDE_TIMEOUT_IRQ(to_irq));

	always #50 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic comb(input logic [1:0] fn, input logic n, input logic w);
		case (fn)
			2'h0: return n & w;
			2'h1: return n | w;
			2'h2: return ~(n | w);
			default: return ~(n & w);
		endcase
	endfunction

	task finish_test;
		$display("checked=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task check_reg(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// inputs always move 10 ns after the rising edge
	task step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask

	task wreg(input logic [3:0] a, input logic [7:0] v);
		step(1);
		wr = 1'b1;
		addr = a;
		wdata = v;
		step(1);
		wr = 1'b0;
	endtask

	// read data is registered, so allow one extra edge
	task creg(input logic [3:0] a, input logic [7:0] exp);
		step(1);
		addr = a;
		step(2);
		check_reg(rdata, exp);
	endtask

	// edge pulses last one cycle, so look once per cycle
	task watch(input int n);
		repeat (n) begin
			step(1);
			n_rise += (e_rise === 1'b1);
			n_fall += (e_fall === 1'b1);
		end
	endtask

	// pulse the unselected pin first: it must leave the flags alone
	task demod_case(input logic sel, input logic [1:0] edg, input logic [1:0] filt, input int w,
		input logic [1:0] ex);
		wreg(4'h1, {1'b1, sel, edg, filt, 2'h3});
		n_rise = 0;
		n_fall = 0;
		watch(12);
		pins[!sel] = 1'b1;
		watch(20);
		pins[!sel] = 1'b0;
		watch(20);
		pins[sel] = 1'b1;
		watch(w);
		pins[sel] = 1'b0;
		watch(20);
		creg(4'h1, {1'b1, sel, edg, filt, ex});
		check_reg(n_rise[7:0], {7'h00, ex[1]});
		check_reg(n_fall[7:0], {7'h00, ex[0]});
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		finish_test;
	end

	initial begin
		repeat (16) @(posedge clk);
		#10;
		rst_n = 1'b1;
		creg(4'h1, 8'h00);
		creg(4'h2, 8'h00);
		check_bit(n_out, 1'b1);
		check_bit(w_out, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			d = seed[7:0];
			ua = 4'h3 + {2'h0, seed[9:8]};
			wreg(4'h2, d);
			wreg(ua, ~d);
			creg(4'h2, d & 8'hdf);
			creg(ua, 8'h00);
			check_bit(w_run, d[7]);
			check_bit(single, d[6]);
		end
		wreg(4'h2, 8'h00);
		$display("test registers done");
		for (int fn = 0; fn < 4; fn++) begin
			for (int b = 0; b < 4; b++) begin
				wreg(4'h1, {2'b01, fn[1:0], 2'b00, b[1:0]});
				step(3);
				check_bit(n_out, ~b[1]);
				check_bit(w_out, ~b[0]);
				check_bit(comb_pin, comb(fn[1:0], ~b[1], ~b[0]));
			end
		end
		wreg(4'h1, 8'h00);
		seed = xs(seed);
		port_comb = seed[0];
		step(3);
		check_bit(comb_pin, seed[0]);
		$display("test combine done");
		wreg(4'h1, 8'h04);
		step(2);
		check_bit(pp, 1'b1);
		wreg(4'h1, 8'h00);
		step(2);
		check_bit(pp, 1'b0);
		wreg(4'h1, 8'h08);
		step(2);
		check_bit(w_out, 1'b0);
		wreg(4'h1, 8'h0d);
		step(2);
		check_bit(w_out, 1'b1);
		wreg(4'h2, 8'h80);
		wreg(4'h1, 8'h09);
		step(2);
		check_bit(w_out, 1'b0);
		wreg(4'h2, 8'h00);
		$display("test submode done");
		wreg(4'h1, 8'h02);
		step(2);
		check_bit(n_out, 1'b0);
		n_run = 1'b1;
		step(2);
		check_bit(n_out, 1'b1);
		n_tog = 1'b1;
		step(1);
		n_tog = 1'b0;
		step(1);
		check_bit(n_out, 1'b0);
		n_run = 1'b0;
		wreg(4'h2, 8'h83);
		step(2);
		check_bit(w_out, 1'b0);
		check_bit(wide_pin, 1'b0);
		term = 1'b1;
		step(1);
		term = 1'b0;
		check_bit(to_irq, 1'b1);
		check_bit(w_out, 1'b1);
		step(1);
		check_bit(wide_pin, 1'b1);
		creg(4'h2, 8'ha3);
		wreg(4'h2, 8'h83);
		creg(4'h2, 8'ha3);
		wreg(4'h2, 8'ha3);
		creg(4'h2, 8'h83);
		wreg(4'h2, 8'h85);
		term = 1'b1;
		cap = 1'b1;
		step(1);
		term = 1'b0;
		cap = 1'b0;
		check_bit(to_irq, 1'b0);
		check_bit(cap_irq, 1'b1);
		wreg(4'h2, 8'h81);
		cap = 1'b1;
		step(1);
		cap = 1'b0;
		check_bit(cap_irq, 1'b0);
		port_wide = 1'b1;
		wreg(4'h2, 8'h20);
		step(2);
		check_bit(wide_pin, 1'b1);
		$display("test start done");
		for (int p = 0; p < 4; p++) begin
			wreg(4'h2, {2'b10, 1'b0, p[1:0], 3'h0});
			step(4);
			ticks = 0;
			repeat (64) begin
				if (tick === 1'b1)
					ticks++;
				step(1);
			end
			check_reg(ticks[7:0], 8'h40 >> p);
		end
		wreg(4'h2, 8'h00);
		$display("test prescale done");
		wreg(4'h1, 8'h80);
		step(2);
		check_bit(demod, 1'b1);
		check_bit(edge_en, 1'b1);
		wreg(4'h2, 8'h40);
		step(1);
		check_bit(edge_en, 1'b0);
		check_bit(single, 1'b0);
		wreg(4'h2, 8'h00);
		for (int e = 0; e < 3; e++) begin
			for (int s = 0; s < 2; s++) begin
				demod_case(s[0], e[1:0], 2'h0, 10, {e != 0, e != 1});
			end
		end
		wreg(4'h1, 8'he0);
		creg(4'h1, 8'he3);
		wreg(4'h1, 8'he2);
		creg(4'h1, 8'he1);
		demod_case(1'b0, 2'h2, 2'h1, 2, 2'h0);
		demod_case(1'b0, 2'h2, 2'h1, 6, 2'h3);
		demod_case(1'b0, 2'h2, 2'h2, 6, 2'h0);
		demod_case(1'b0, 2'h2, 2'h2, 12, 2'h3);
		demod_case(1'b0, 2'h3, 2'h0, 10, 2'h0);
		demod_case(1'b0, 2'h2, 2'h3, 2, 2'h3);
		$display("test demod done");
		finish_test;
	end
endmodule

`default_nettype wire
